// ===== hdl/fcsd_host.sv
// Host controller that issues flash command sequences on the parallel bus
`timescale 1ns/100ps
module fcsd_host (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [3:0]  cmd_op_i,
    input  wire logic [19:0] cmd_addr_i,
    input  wire logic [15:0] cmd_data_i,
    input  wire logic        byte_mode_i,
    input  wire logic        variant2_i,
    output logic             cmd_ready_o,
    output logic             cmd_done_o,
    output logic             cmd_error_o,
    output logic             flash_ce_n_o,
    output logic             flash_we_n_o,
    output logic             flash_oe_n_o,
    output logic             flash_rst_n_o,
    output logic             flash_byte_n_o,
    output logic [19:0]      flash_addr_o,
    output logic [15:0]      flash_dq_o,
    output logic             flash_dq_oe_o
);
    logic [2:0]  step_reg;
    logic [2:0]  last_reg;
    logic        run_reg;
    logic        wait_reg;
    logic [3:0]  op_reg;
    logic [19:0] taddr_reg;
    logic [15:0] tdata_reg;
    logic        start_reg;
    logic [19:0] waddr_reg;
    logic [15:0] wdata_reg;
    logic        wc_busy;
    logic        wc_done;
    logic        user_range_ok;
    logic [2:0]  len_next;
    logic [19:0] seq_addr;
    logic [15:0] seq_data;

    // ************************************************************
    // Request checking
    // ************************************************************
    always_comb begin
        if (variant2_i) begin
            user_range_ok = cmd_addr_i >= fcsd_pkg::SECID_USER_LO_V2 && cmd_addr_i <= fcsd_pkg::SECID_USER_HI_V2;
        end else begin
            user_range_ok = cmd_addr_i >= fcsd_pkg::SECID_USER_LO_V1 && cmd_addr_i <= fcsd_pkg::SECID_USER_HI_V1;
        end
    end

    always_comb begin
        case (fcsd_pkg::fcsd_op_t'(cmd_op_i))
            fcsd_pkg::FCSD_OP_PROGRAM:      len_next = 3'd4;
            fcsd_pkg::FCSD_OP_SECTOR_ERASE: len_next = 3'd6;
            fcsd_pkg::FCSD_OP_BLOCK_ERASE:  len_next = 3'd6;
            fcsd_pkg::FCSD_OP_CHIP_ERASE:   len_next = 3'd6;
            fcsd_pkg::FCSD_OP_SUSPEND:      len_next = 3'd1;
            fcsd_pkg::FCSD_OP_RESUME:       len_next = 3'd1;
            fcsd_pkg::FCSD_OP_SECID_QUERY:  len_next = 3'd3;
            fcsd_pkg::FCSD_OP_SECID_PROG:   len_next = 3'd4;
            fcsd_pkg::FCSD_OP_SECID_LOCK:   len_next = 3'd4;
            fcsd_pkg::FCSD_OP_ID_ENTRY:     len_next = 3'd3;
            fcsd_pkg::FCSD_OP_CFI_ENTRY:    len_next = 3'd3;
            fcsd_pkg::FCSD_OP_CFI_SHORT:    len_next = 3'd1;
            fcsd_pkg::FCSD_OP_EXIT_LONG:    len_next = 3'd3;
            fcsd_pkg::FCSD_OP_EXIT_SHORT:   len_next = 3'd1;
            default:                        len_next = 3'd0;
        endcase
        // Refuse targets the device would not accept
        if (cmd_op_i == 4'(fcsd_pkg::FCSD_OP_SECID_PROG) && !user_range_ok) begin
            len_next = 3'd0;
        end
        if (cmd_op_i == 4'(fcsd_pkg::FCSD_OP_SECID_LOCK) && byte_mode_i) begin
            len_next = 3'd0;
        end
    end

    // ************************************************************
    // Address and data of the current step
    // ************************************************************
    always_comb begin
        // Unlock pair opens every multi-cycle sequence; upper data byte is zero
        if (step_reg == 3'd0 || step_reg == 3'd3) begin
            seq_addr = {9'h000, fcsd_pkg::ADDR_UNLOCK1};
            seq_data = {8'h00, fcsd_pkg::DATA_UNLOCK1};
        end else if (step_reg == 3'd1 || step_reg == 3'd4) begin
            seq_addr = {9'h000, fcsd_pkg::ADDR_UNLOCK2};
            seq_data = {8'h00, fcsd_pkg::DATA_UNLOCK2};
        end else begin
            seq_addr = {9'h000, fcsd_pkg::ADDR_UNLOCK1};
            seq_data = 16'h0000;
        end
        case (fcsd_pkg::fcsd_op_t'(op_reg))
            fcsd_pkg::FCSD_OP_PROGRAM: begin
                if (step_reg == 3'd2) seq_data = {8'h00, fcsd_pkg::CMD_PROGRAM};
                if (step_reg == 3'd3) begin
                    seq_addr = taddr_reg;
                    seq_data = tdata_reg;
                end
            end
            fcsd_pkg::FCSD_OP_SECTOR_ERASE, fcsd_pkg::FCSD_OP_BLOCK_ERASE, fcsd_pkg::FCSD_OP_CHIP_ERASE: begin
                if (step_reg == 3'd2) seq_data = {8'h00, fcsd_pkg::CMD_ERASE_SETUP};
                if (step_reg == 3'd5) begin
                    if (op_reg == 4'(fcsd_pkg::FCSD_OP_SECTOR_ERASE)) begin
                        seq_addr = {taddr_reg[19:11], 11'h000};
                        seq_data = {8'h00, fcsd_pkg::CMD_SECTOR_ER};
                    end else if (op_reg == 4'(fcsd_pkg::FCSD_OP_BLOCK_ERASE)) begin
                        seq_addr = {taddr_reg[19:15], 15'h0000};
                        seq_data = {8'h00, fcsd_pkg::CMD_BLOCK_ER};
                    end else begin
                        seq_data = {8'h00, fcsd_pkg::CMD_CHIP_ER};
                    end
                end
            end
            fcsd_pkg::FCSD_OP_SUSPEND: begin
                seq_addr = taddr_reg;
                seq_data = {8'h00, fcsd_pkg::CMD_SUSPEND};
            end
            fcsd_pkg::FCSD_OP_RESUME: begin
                seq_addr = taddr_reg;
                seq_data = {8'h00, fcsd_pkg::CMD_RESUME};
            end
            fcsd_pkg::FCSD_OP_SECID_QUERY: begin
                if (step_reg == 3'd2) seq_data = {8'h00, fcsd_pkg::CMD_SECID_QUERY};
            end
            fcsd_pkg::FCSD_OP_SECID_PROG: begin
                if (step_reg == 3'd2) seq_data = {8'h00, fcsd_pkg::CMD_SECID_PROG};
                if (step_reg == 3'd3) begin
                    seq_addr = taddr_reg;
                    seq_data = tdata_reg;
                end
            end
            fcsd_pkg::FCSD_OP_SECID_LOCK: begin
                if (step_reg == 3'd2) seq_data = {8'h00, fcsd_pkg::CMD_SECID_LOCK};
                if (step_reg == 3'd3) begin
                    seq_addr = taddr_reg;
                    seq_data = fcsd_pkg::DATA_LOCK_WORD;
                end
            end
            fcsd_pkg::FCSD_OP_ID_ENTRY, fcsd_pkg::FCSD_OP_CFI_ENTRY: begin
                if (step_reg == 3'd2) begin
                    seq_addr[fcsd_pkg::BANK_MSB:fcsd_pkg::BANK_LSB] = taddr_reg[19:18];
                    seq_data = {8'h00, (op_reg == 4'(fcsd_pkg::FCSD_OP_ID_ENTRY)) ?
                                fcsd_pkg::CMD_ID_ENTRY : fcsd_pkg::CMD_CFI_ENTRY};
                end
            end
            fcsd_pkg::FCSD_OP_CFI_SHORT: begin
                seq_addr = {taddr_reg[19:18], 7'h00, fcsd_pkg::ADDR_CFI_SHORT};
                seq_data = {8'h00, fcsd_pkg::CMD_CFI_ENTRY};
            end
            fcsd_pkg::FCSD_OP_EXIT_LONG: begin
                if (step_reg == 3'd2) seq_data = {8'h00, fcsd_pkg::CMD_EXIT};
            end
            fcsd_pkg::FCSD_OP_EXIT_SHORT: begin
                seq_addr = taddr_reg;
                seq_data = {8'h00, fcsd_pkg::CMD_EXIT};
            end
            default: begin
                seq_data = 16'h0000;
            end
        endcase
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // A sequence always runs to its last write; it cannot be cut short
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_reg     <= 1'b0;
            wait_reg    <= 1'b0;
            step_reg    <= 3'd0;
            last_reg    <= 3'd0;
            op_reg      <= 4'h0;
            taddr_reg   <= 20'h00000;
            tdata_reg   <= 16'h0000;
            start_reg   <= 1'b0;
            waddr_reg   <= 20'h00000;
            wdata_reg   <= 16'h0000;
            cmd_ready_o <= 1'b0;
            cmd_done_o  <= 1'b0;
            cmd_error_o <= 1'b0;
        end else begin
            start_reg   <= 1'b0;
            cmd_done_o  <= 1'b0;
            cmd_error_o <= 1'b0;
            cmd_ready_o <= !run_reg && !(cmd_valid_i && cmd_ready_o);
            if (!run_reg && cmd_valid_i && cmd_ready_o) begin
                if (len_next == 3'd0) begin
                    cmd_error_o <= 1'b1;
                end else begin
                    run_reg   <= 1'b1;
                    step_reg  <= 3'd0;
                    last_reg  <= len_next - 3'd1;
                    op_reg    <= cmd_op_i;
                    taddr_reg <= cmd_addr_i;
                    tdata_reg <= cmd_data_i;
                end
            end else if (run_reg && !wait_reg && !wc_busy) begin
                start_reg <= 1'b1;
                waddr_reg <= seq_addr;
                wdata_reg <= seq_data;
                wait_reg  <= 1'b1;
            end else if (run_reg && wc_done) begin
                wait_reg <= 1'b0;
                if (step_reg == last_reg) begin
                    run_reg    <= 1'b0;
                    cmd_done_o <= 1'b1;
                end else begin
                    step_reg <= step_reg + 3'd1;
                end
            end
        end
    end

    // ************************************************************
    // Static pins
    // ************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flash_oe_n_o   <= 1'b1;
            flash_rst_n_o  <= 1'b0;
            flash_byte_n_o <= 1'b1;
        end else begin
            flash_oe_n_o   <= 1'b1;
            flash_rst_n_o  <= 1'b1;
            flash_byte_n_o <= !byte_mode_i;
        end
    end

    fcsd_write_cycle u_cycle (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .start_i  (start_reg),
        .addr_i   (waddr_reg),
        .data_i   (wdata_reg),
        .busy_o   (wc_busy),
        .done_o   (wc_done),
        .ce_n_o   (flash_ce_n_o),
        .we_n_o   (flash_we_n_o),
        .addr_o   (flash_addr_o),
        .dq_o     (flash_dq_o),
        .dq_oe_o  (flash_dq_oe_o)
    );
endmodule

// ===== hdl/fcsd_write_cycle.sv
// One asynchronous bus write cycle: chip select, write strobe, address and data
`timescale 1ns/100ps
module fcsd_write_cycle (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        start_i,
    input  wire logic [19:0] addr_i,
    input  wire logic [15:0] data_i,
    output logic             busy_o,
    output logic             done_o,
    output logic             ce_n_o,
    output logic             we_n_o,
    output logic [19:0]      addr_o,
    output logic [15:0]      dq_o,
    output logic             dq_oe_o
);
    typedef enum logic [1:0] {FCSD_WC_IDLE, FCSD_WC_SETUP, FCSD_WC_PULSE, FCSD_WC_HOLD} fcsd_wc_t;
    fcsd_wc_t   st_reg;
    logic [3:0] cnt_reg;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg  <= FCSD_WC_IDLE;
            cnt_reg <= 4'h0;
            done_o  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (st_reg)
                FCSD_WC_IDLE: begin
                    if (start_i) begin
                        st_reg  <= FCSD_WC_SETUP;
                        cnt_reg <= fcsd_pkg::SETUP_CYC - 4'h1;
                    end
                end
                FCSD_WC_SETUP: begin
                    if (cnt_reg == 4'h0) begin
                        st_reg  <= FCSD_WC_PULSE;
                        cnt_reg <= fcsd_pkg::PULSE_CYC - 4'h1;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                FCSD_WC_PULSE: begin
                    if (cnt_reg == 4'h0) begin
                        st_reg  <= FCSD_WC_HOLD;
                        cnt_reg <= fcsd_pkg::HOLD_CYC - 4'h1;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                FCSD_WC_HOLD: begin
                    if (cnt_reg == 4'h0) begin
                        st_reg <= FCSD_WC_IDLE;
                        done_o <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: st_reg <= FCSD_WC_IDLE;
            endcase
        end
    end

    // Address is launched at setup so it is stable before the strobe falls
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_o  <= 1'b0;
            ce_n_o  <= 1'b1;
            we_n_o  <= 1'b1;
            addr_o  <= 20'h00000;
            dq_o    <= 16'h0000;
            dq_oe_o <= 1'b0;
        end else begin
            if (st_reg == FCSD_WC_IDLE && start_i) begin
                busy_o  <= 1'b1;
                ce_n_o  <= 1'b0;
                addr_o  <= addr_i;
                dq_o    <= data_i;
                dq_oe_o <= 1'b1;
            end
            if (st_reg == FCSD_WC_SETUP && cnt_reg == 4'h0) begin
                we_n_o <= 1'b0;
            end
            if (st_reg == FCSD_WC_PULSE && cnt_reg == 4'h0) begin
                we_n_o <= 1'b1;
            end
            if (st_reg == FCSD_WC_HOLD && cnt_reg == 4'h0) begin
                busy_o  <= 1'b0;
                ce_n_o  <= 1'b1;
                dq_oe_o <= 1'b0;
            end
        end
    end
endmodule

// ===== pkg/fcsd_pkg.sv
// Constants for the host-side flash command sequencer
// Functional notes
// - Commands open with 555/AA then 2AA/55
// - Program: A0 to 555, then address/data
// - Erase: six writes, sector/block/chip final cycle
// - User id program: A5, then address/data
// - Lock-out: 85, then 0000, word mode only
// - Finish all four cycles before read mode
// - Id/CFI entry third cycle, bank bits 19:18
// - Keep hardware reset deasserted while operating
// - Exit F0: long or single form, same effect
package fcsd_pkg;
    localparam logic [10:0] ADDR_UNLOCK1    = 11'h555;
    localparam logic [10:0] ADDR_UNLOCK2    = 11'h2AA;
    localparam logic [10:0] ADDR_CFI_SHORT  = 11'h055;
    localparam logic [7:0]  DATA_UNLOCK1    = 8'hAA;
    localparam logic [7:0]  DATA_UNLOCK2    = 8'h55;
    localparam logic [7:0]  CMD_PROGRAM     = 8'hA0;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0]  CMD_SECTOR_ER   = 8'h50;
    localparam logic [7:0]  CMD_BLOCK_ER    = 8'h30;
    localparam logic [7:0]  CMD_CHIP_ER     = 8'h10;
    localparam logic [7:0]  CMD_SUSPEND     = 8'hB0;
    localparam logic [7:0]  CMD_RESUME      = 8'h30;
    localparam logic [7:0]  CMD_SECID_QUERY = 8'h88;
    localparam logic [7:0]  CMD_SECID_PROG  = 8'hA5;
    localparam logic [7:0]  CMD_SECID_LOCK  = 8'h85;
    localparam logic [7:0]  CMD_ID_ENTRY    = 8'h90;
    localparam logic [7:0]  CMD_CFI_ENTRY   = 8'h98;
    localparam logic [7:0]  CMD_EXIT        = 8'hF0;
    localparam logic [15:0] DATA_LOCK_WORD  = 16'h0000;
    localparam logic [19:0] SECID_USER_LO_V1 = 20'h00008;
    localparam logic [19:0] SECID_USER_HI_V1 = 20'h00087;
    localparam logic [19:0] SECID_USER_LO_V2 = 20'hC0008;
    localparam logic [19:0] SECID_USER_HI_V2 = 20'hC0087;
    localparam int          BANK_MSB        = 19;
    localparam int          BANK_LSB        = 18;
    // Bus cycle phase lengths at 4 ns per cycle
    localparam int          T_SETUP_NS      = 20;
    localparam int          T_PULSE_NS      = 40;
    localparam int          T_HOLD_NS       = 20;
    localparam int          CLK_NS          = 4;
    localparam logic [3:0]  SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  PULSE_CYC = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  HOLD_CYC  = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
    typedef enum logic [3:0] {
        FCSD_OP_PROGRAM, FCSD_OP_SECTOR_ERASE, FCSD_OP_BLOCK_ERASE, FCSD_OP_CHIP_ERASE,
        FCSD_OP_SUSPEND, FCSD_OP_RESUME, FCSD_OP_SECID_QUERY, FCSD_OP_SECID_PROG,
        FCSD_OP_SECID_LOCK, FCSD_OP_ID_ENTRY, FCSD_OP_CFI_ENTRY, FCSD_OP_CFI_SHORT,
        FCSD_OP_EXIT_LONG, FCSD_OP_EXIT_SHORT
    } fcsd_op_t;
endpackage

// ===== tb/fcsd_flash_model.sv
// Behavioural flash device: logs write cycles and tracks the command decoder
`timescale 1ns/100ps
module fcsd_flash_model (
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        rst_n_i,
    input  wire logic        byte_n_i,
    input  wire logic [19:0] addr_i,
    input  wire logic [15:0] dq_i
);
    logic [19:0] log_a[$];
    logic [15:0] log_d[$];
    logic [10:0] a;
    logic [7:0]  d;
    logic [7:0]  last_cmd;
    logic        id_mode;
    logic        secid_mode;
    int          step;
    // Data is taken on the rising strobe, as the device latches it
    always @(posedge we_n_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step = 0;
            id_mode = 1'b0;
            secid_mode = 1'b0;
        end else if (!ce_n_i) begin
            log_a.push_back(addr_i);
            log_d.push_back(dq_i);
            a = addr_i[10:0];
            d = dq_i[7:0];
            if (step == 6) begin
                step = 0;
            end else if (step == 5) begin
                last_cmd = d;
                step = 0;
            end else if (step == 0 && a == 11'h555 && d == 8'hAA || step == 3 && a == 11'h555 && d == 8'hAA) begin
                step = step + 1;
            end else if ((step == 1 || step == 4) && a == 11'h2AA && d == 8'h55) begin
                step = step + 1;
            end else if (step == 2 && a == 11'h555) begin
                last_cmd = d;
                step = (d == 8'h80) ? 3 : (d == 8'hA0 || d == 8'hA5 || d == 8'h85) ? 6 : 0;
                if (d == 8'h90 || d == 8'h98) id_mode = 1'b1;
                if (d == 8'h88) secid_mode = 1'b1;
                if (d == 8'hF0) {id_mode, secid_mode} = 2'b00;
            end else if (step == 0 && (d == 8'hB0 || d == 8'h30 || d == 8'hF0 || d == 8'h98 && a == 11'h055)) begin
                last_cmd = d;
                id_mode = id_mode || d == 8'h98;
                if (d == 8'hF0) {id_mode, secid_mode} = 2'b00;
            end else begin
                step = 0;
            end
        end
    end
endmodule

// ===== tb/fcsd_host_checker.sv
// Concurrent checks on the ports of the host flash command sequencer
`timescale 1ns/100ps
module fcsd_host_checker (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [3:0]  cmd_op_i,
    input  wire logic [19:0] cmd_addr_i,
    input  wire logic        byte_mode_i,
    input  wire logic        variant2_i,
    input  wire logic        cmd_ready_o,
    input  wire logic        cmd_done_o,
    input  wire logic        cmd_error_o,
    input  wire logic        flash_ce_n_o,
    input  wire logic        flash_we_n_o,
    input  wire logic        flash_rst_n_o,
    input  wire logic        flash_byte_n_o,
    input  wire logic [19:0] flash_addr_o,
    input  wire logic [15:0] flash_dq_o,
    input  wire logic        flash_dq_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic take;
    assign take = cmd_valid_i && cmd_ready_o;
    // ****************************************
    // Properties
    // ****************************************
    property p_rst_high; cmd_ready_o |-> flash_rst_n_o; endproperty
    a_rst_high: assert property (p_rst_high) else $error("flash reset low while idle");
    property p_we_in_ce; !flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o; endproperty
    a_we_in_ce: assert property (p_we_in_ce) else $error("write strobe outside select");
    property p_hold; !flash_we_n_o && !$past(flash_we_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o);
    endproperty
    a_hold: assert property (p_hold) else $error("address or data moved under strobe");
    property p_pulse; $fell(flash_we_n_o) |-> !flash_we_n_o [*8]; endproperty
    a_pulse: assert property (p_pulse) else $error("write strobe too short");
    property p_idle_bus; cmd_ready_o |-> flash_ce_n_o; endproperty
    a_idle_bus: assert property (p_idle_bus) else $error("bus active while idle");
    property p_lock_byte; take && cmd_op_i == 4'h8 && byte_mode_i |=> cmd_error_o; endproperty
    a_lock_byte: assert property (p_lock_byte) else $error("lock-out in byte mode taken");
    property p_secid_range;
        take && cmd_op_i == 4'h7 && !variant2_i && (cmd_addr_i < 20'h00008 || cmd_addr_i > 20'h00087)
        |=> cmd_error_o;
    endproperty
    a_secid_range: assert property (p_secid_range) else $error("user id address out of range taken");
    property p_single; take && cmd_op_i == 4'h4 |-> ##[18:40] cmd_done_o; endproperty
    a_single: assert property (p_single) else $error("single write not done in time");
    property p_byte_pin; $past(arst_n_i) && $stable(byte_mode_i) |-> flash_byte_n_o == !byte_mode_i;
    endproperty
    a_byte_pin: assert property (p_byte_pin) else $error("byte pin wrong");
    property p_done_pulse; cmd_done_o |=> !cmd_done_o && !cmd_error_o; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
endmodule
bind fcsd_host fcsd_host_checker u_fcsd_host_checker (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_addr_i(cmd_addr_i), .byte_mode_i(byte_mode_i), .variant2_i(variant2_i),
    .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o), .cmd_error_o(cmd_error_o),
    .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o), .flash_rst_n_o(flash_rst_n_o),
    .flash_byte_n_o(flash_byte_n_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o)
);

// ===== tb/flash_command_sequence_decoder_tb_top.sv
// Self-checking testbench for the host flash command sequencer
`timescale 1ns/100ps
module flash_command_sequence_decoder_tb_top;
    logic clk_i = 1'b0, arst_n_i = 1'b0, cmd_valid_i = 1'b0, byte_mode_i = 1'b0, variant2_i = 1'b0;
    logic [3:0]  cmd_op_i = 4'h0;
    logic [19:0] cmd_addr_i = 20'h00000;
    logic [15:0] cmd_data_i = 16'h0000;
    logic        cmd_ready_o, cmd_done_o, cmd_error_o, ce_n, we_n, oe_n, rst_n, byte_n, dq_oe;
    logic [19:0] f_addr;
    logic [15:0] f_dq;
    logic [19:0] ea[$], em[$];
    logic [15:0] ed[$], dm[$];
    int          bad_count = 0, checks = 0, cyc = 0;
    always #2 clk_i = ~clk_i;
    fcsd_host u_fcsd_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
        .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .byte_mode_i(byte_mode_i), .variant2_i(variant2_i),
        .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o), .cmd_error_o(cmd_error_o), .flash_ce_n_o(ce_n),
        .flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .flash_rst_n_o(rst_n), .flash_byte_n_o(byte_n),
        .flash_addr_o(f_addr), .flash_dq_o(f_dq), .flash_dq_oe_o(dq_oe));
    fcsd_flash_model u_fcsd_flash_model (.ce_n_i(ce_n), .we_n_i(we_n), .rst_n_i(rst_n), .byte_n_i(byte_n),
        .addr_i(f_addr), .dq_i(f_dq));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic add(input logic [19:0] a, input logic [19:0] am, input logic [15:0] d, input logic [15:0] m);
        ea.push_back(a); em.push_back(am); ed.push_back(d); dm.push_back(m);
    endtask
    task automatic unl;
        add(20'h00555, 20'h007FF, 16'h00AA, 16'h00FF);
        add(20'h002AA, 20'h007FF, 16'h0055, 16'h00FF);
    endtask
    task automatic cm(input logic [7:0] c);
        add(20'h00555, 20'h007FF, {8'h00, c}, 16'h00FF);
    endtask
    // Issues one request, waits for its answer and compares every logged write
    task automatic run(input logic [3:0] op, input logic [19:0] a, input logic [15:0] d, input logic err);
        int n;
        u_fcsd_flash_model.log_a.delete();
        u_fcsd_flash_model.log_d.delete();
        @(posedge clk_i);
        cmd_valid_i <= 1'b1; cmd_op_i <= op; cmd_addr_i <= a; cmd_data_i <= d;
        do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
        cmd_valid_i <= 1'b0;
        n = 0;
        do begin @(posedge clk_i); n++; end while (cmd_done_o !== 1'b1 && cmd_error_o !== 1'b1 && n < 400);
        chk("refused", {cmd_done_o, cmd_error_o}, {!err, err});
        if (err) ea.delete();
        chk("write count", u_fcsd_flash_model.log_a.size(), ea.size());
        for (int i = 0; i < ea.size() && i < u_fcsd_flash_model.log_a.size(); i++) begin
            chk("write addr", u_fcsd_flash_model.log_a[i] & em[i], ea[i] & em[i]);
            chk("write data", u_fcsd_flash_model.log_d[i] & dm[i], ed[i] & dm[i]);
        end
        ea.delete(); em.delete(); ed.delete(); dm.delete();
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_program;
        unl; cm(8'hA0); add(20'hABCDE, 20'hFFFFF, 16'h1234, 16'hFFFF); run(4'h0, 20'hABCDE, 16'h1234, 1'b0);
        chk("last cmd", u_fcsd_flash_model.last_cmd, 8'hA0);
    endtask
    task automatic t_erase;
        unl; cm(8'h80); unl; add(20'hFF800, 20'hFFFFF, 16'h0050, 16'h00FF); run(4'h1, 20'hFFFFF, 16'h0, 1'b0);
        unl; cm(8'h80); unl; add(20'h78000, 20'hFFFFF, 16'h0030, 16'h00FF); run(4'h2, 20'h7FFFF, 16'h0, 1'b0);
        unl; cm(8'h80); unl; add(20'h00555, 20'h007FF, 16'h0010, 16'h00FF); run(4'h3, 20'h00000, 16'h0, 1'b0);
    endtask
    task automatic t_single;
        add(20'h0, 20'h0, 16'h00B0, 16'h00FF); run(4'h4, 20'h12345, 16'h0, 1'b0);
        add(20'h0, 20'h0, 16'h0030, 16'h00FF); run(4'h5, 20'h54321, 16'h0, 1'b0);
        add(20'hC0055, 20'hC07FF, 16'h0098, 16'h00FF); run(4'hB, 20'hC0000, 16'h0, 1'b0);
        chk("id mode on", u_fcsd_flash_model.id_mode, 1'b1);
        add(20'h0, 20'h0, 16'h00F0, 16'h00FF); run(4'hD, 20'h00777, 16'h0, 1'b0);
        chk("id mode off", u_fcsd_flash_model.id_mode, 1'b0);
    endtask
    task automatic t_three;
        unl; cm(8'h88); run(4'h6, 20'h0, 16'h0, 1'b0);
        chk("secid mode", u_fcsd_flash_model.secid_mode, 1'b1);
        unl; add(20'h80555, 20'hC07FF, 16'h0090, 16'h00FF); run(4'h9, 20'h80000, 16'h0, 1'b0);
        unl; add(20'h40555, 20'hC07FF, 16'h0098, 16'h00FF); run(4'hA, 20'h40000, 16'h0, 1'b0);
        unl; cm(8'hF0); run(4'hC, 20'h0, 16'h0, 1'b0);
        chk("modes off", {u_fcsd_flash_model.id_mode, u_fcsd_flash_model.secid_mode}, 2'b00);
    endtask
    task automatic t_secid;
        logic [19:0] ok[4] = '{20'h00008, 20'h00087, 20'hC0008, 20'hC0087};
        for (int i = 0; i < 4; i++) begin
            variant2_i <= (i > 1);
            unl; cm(8'hA5); add(ok[i], 20'hFFFFF, 16'hFFFE, 16'hFFFF); run(4'h7, ok[i], 16'hFFFE, 1'b0);
        end
        run(4'h7, 20'h00008, 16'h0, 1'b1);
        variant2_i <= 1'b0;
        run(4'h7, 20'h00088, 16'h0, 1'b1);
        run(4'h7, 20'h00007, 16'h0, 1'b1);
    endtask
    task automatic t_lock;
        unl; cm(8'h85); add(20'h3C3C3, 20'hFFFFF, 16'h0000, 16'hFFFF); run(4'h8, 20'h3C3C3, 16'h0, 1'b0);
        byte_mode_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("byte pin", byte_n, 1'b0);
        run(4'h8, 20'h00000, 16'h0, 1'b1);
        byte_mode_i <= 1'b0;
        run(4'hE, 20'h00000, 16'h0, 1'b1);
    endtask
    // ****************************************
    // Run control
    // ****************************************
    task automatic report_and_stop;
        $display("mismatches %0d of %0d comparisons", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Ceiling is about six times the expected run length
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        chk("flash reset in reset", rst_n, 1'b0);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("flash reset after", rst_n, 1'b1);
        chk("read strobe", oe_n, 1'b1);
        t_program;
        t_erase;
        t_single;
        t_three;
        t_secid;
        t_lock;
        report_and_stop();
    end
endmodule
